// ---- logic/rx_term_pkg.sv ----
// package for the receive termination control block: register map, field layout, modes
// assumes: apb slave with 32-bit data, one aligned word per register
`default_nettype none
package rx_term_pkg;
   localparam int NUM_CHANNELS = 29;
   localparam int CHAN_IDX_W   = 5;
   localparam int ADDR_W       = 12;
   localparam int CFG_W        = 8;

   // one config word per channel, word aligned from base; status words follow
   localparam logic [ADDR_W-1:0] CFG_BASE    = 12'h000;
   localparam logic [ADDR_W-1:0] STATUS_BASE = 12'h100;
   localparam logic [ADDR_W-1:0] PIN_STATUS  = 12'h200;
   localparam int WORD_SHIFT = 2;

   // field positions of receive_termination_config
   localparam int TERM_LO_POS    = 0;
   localparam int TERM_HI_POS    = 1;
   localparam int TERM_EXT_POS   = 2;
   localparam int SINGLE_POS     = 3;
   localparam int PART_FULL_POS  = 4;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

   typedef enum logic [1:0] {
      MATCH_EXTERNAL,
      MATCH_PARTIAL_INTERNAL,
      MATCH_FULL_INTERNAL
   } match_mode_t;

   typedef enum logic [1:0] {
      CABLE_TP100,
      CABLE_TP110,
      CABLE_TP120,
      CABLE_COAX75
   } cable_code_t;

   localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage
`default_nettype wire

// ---- logic/rx_term_channel.sv ----
// one channel's termination decode: register bits plus global pin to effective mode
// assumes: inputs are synchronous to clk_sys; purely combinational
`default_nettype none
module rx_term_channel
   import rx_term_pkg::*;
(
   // configuration
   input  wire logic [CFG_W-1:0] cfg,
   input  wire logic             hiz_release,
   // line side
   input  wire logic             tip_in,
   input  wire logic             ring_in,
   // decoded termination
   output logic                  diff_select,
   output logic                  line_sample,
   output match_mode_t           match_mode,
   output logic [1:0]            resistor_code,
   output logic                  resistor_enable
);
   always_comb begin
      diff_select = !cfg[SINGLE_POS];
      // single-ended listens on tip alone
      line_sample = diff_select ? (tip_in ^ ring_in) : tip_in;
      match_mode  = MATCH_EXTERNAL;
      if (!hiz_release) begin
         match_mode = MATCH_EXTERNAL;
      end else if (!diff_select) begin
         match_mode = MATCH_EXTERNAL;
      end else if (cfg[TERM_EXT_POS]) begin
         match_mode = MATCH_EXTERNAL;
      end else if (!cfg[PART_FULL_POS]) begin
         match_mode = MATCH_PARTIAL_INTERNAL;
      end else begin
         match_mode = MATCH_FULL_INTERNAL;
      end
      // value field only matters with internal matching; external ignores it
      resistor_enable = (match_mode != MATCH_EXTERNAL);
      resistor_code   = resistor_enable ? cfg[TERM_HI_POS:TERM_LO_POS] : 2'h0;
   end
endmodule
`default_nettype wire

// ---- logic/rx_termination_control.sv ----
// receive termination control for 29 channels with apb register access
// assumes: global pin is asynchronous to clk_sys; apb master on clk_sys
//
// What this block does
// - Bit 3 of each channel's config picks differential or single-ended reception.
// - Differential uses tip and ring, single-ended uses tip alone.
// - Global pin low forces external matching on all 29 channels, ignoring match bits.
// - Global pin high lets each channel set matching from its own bits.
// - Bit 2 zero enables internal matching.
// - Bit 2 one selects external matching and ignores value field and bit 4.
// - Bit 4 chooses partial (0) or full (1) internal matching.
// - The two-bit value field sets the resistor for 100, 110, 120 ohm pair or 75 ohm coax.
// - Single-ended reception supports only external matching.
`default_nettype none
module rx_termination_control
   import rx_term_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    reset_n,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [ADDR_W-1:0]       paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   // global pin
   input  wire logic                    global_hiz_force_pin,
   // line side
   input  wire logic [NUM_CHANNELS-1:0] line_tip_input,
   input  wire logic [NUM_CHANNELS-1:0] line_ring_input,
   // termination controls to the analog networks
   output logic [NUM_CHANNELS-1:0]      diff_select,
   output logic [NUM_CHANNELS-1:0]      line_sample,
   output logic [NUM_CHANNELS-1:0]      internal_programmable_resistor_en,
   output logic [NUM_CHANNELS-1:0]      full_internal_en,
   output logic [2*NUM_CHANNELS-1:0]    resistor_code
);
   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic                    pin_meta;
   logic                    pin_sync;
   logic [NUM_CHANNELS-1:0] tip_meta;
   logic [NUM_CHANNELS-1:0] tip_sync;
   logic [NUM_CHANNELS-1:0] ring_meta;
   logic [NUM_CHANNELS-1:0] ring_sync;

   // an open pin reads high at the board; reset keeps all lines high impedance
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= global_hiz_force_pin;
         pin_sync <= pin_meta;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tip_meta  <= '0;
         tip_sync  <= '0;
         ring_meta <= '0;
         ring_sync <= '0;
      end else begin
         tip_meta  <= line_tip_input;
         tip_sync  <= tip_meta;
         ring_meta <= line_ring_input;
         ring_sync <= ring_meta;
      end
   end

   // ==========================================================
   // register file
   // ==========================================================
   logic [CFG_W-1:0]        receive_termination_config [NUM_CHANNELS];
   logic                    access;
   logic [ADDR_W-1:0]       word_off;
   logic [CHAN_IDX_W-1:0]   chan_idx;
   logic                    in_cfg;
   logic                    in_status;
   logic                    in_pin;
   logic [ADDR_W-1:0]       status_off;

   assign access     = psel && penable;
   assign word_off   = paddr - CFG_BASE;
   assign status_off = paddr - STATUS_BASE;
   assign chan_idx   = in_cfg ? word_off[WORD_SHIFT +: CHAN_IDX_W]
                              : status_off[WORD_SHIFT +: CHAN_IDX_W];
   assign in_cfg     = (paddr[1:0] == 2'h0) && (paddr >= CFG_BASE)
                       && (word_off < ADDR_W'(NUM_CHANNELS << WORD_SHIFT));
   assign in_status  = (paddr[1:0] == 2'h0) && (paddr >= STATUS_BASE)
                       && (status_off < ADDR_W'(NUM_CHANNELS << WORD_SHIFT));
   assign in_pin     = (paddr == PIN_STATUS);

   // zero-wait slave; unmapped or status writes answer with an error
   assign pready  = 1'b1;
   assign pslverr = access && !(in_cfg || ((in_status || in_pin) && !pwrite));

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            receive_termination_config[i] <= CFG_RESET;
         end
      end else if (access && pwrite && in_cfg) begin
         receive_termination_config[chan_idx] <= pwdata[CFG_W-1:0];
      end
   end

   // ==========================================================
   // per-channel decode
   // ==========================================================
   match_mode_t mode [NUM_CHANNELS];

   generate
      for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
         logic [1:0] code;
         rx_term_channel u_chan (
            .cfg             (receive_termination_config[ch]),
            .hiz_release     (pin_sync),
            .tip_in          (tip_sync[ch]),
            .ring_in         (ring_sync[ch]),
            .diff_select     (diff_select[ch]),
            .line_sample     (line_sample[ch]),
            .match_mode      (mode[ch]),
            .resistor_code   (code),
            .resistor_enable (internal_programmable_resistor_en[ch])
         );
         assign full_internal_en[ch]       = (mode[ch] == MATCH_FULL_INTERNAL);
         assign resistor_code[2*ch +: 2]   = code;
      end
   endgenerate

   // ==========================================================
   // read data
   // ==========================================================
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= ZERO_WORD;
      end else if (psel && !penable && !pwrite) begin
         prdata <= ZERO_WORD;
         if (in_cfg) begin
            prdata[CFG_W-1:0] <= receive_termination_config[chan_idx];
         end else if (in_status) begin
            // effective mode: bit0 internal, bit1 full, bit2 differential
            prdata[0] <= internal_programmable_resistor_en[chan_idx];
            prdata[1] <= full_internal_en[chan_idx];
            prdata[2] <= diff_select[chan_idx];
         end else if (in_pin) begin
            prdata[0] <= pin_sync;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/rx_term_asserts.sv ----
// checker: port relations of rx_termination_control
// assumes: bound onto the top module, all on clk_sys
`default_nettype none
module rx_term_asserts
   import rx_term_pkg::*;
(
   // watched ports
   input wire logic                      clk_sys, reset_n, psel, penable, pwrite,
   input wire logic                      pready, pslverr, global_hiz_force_pin,
   input wire logic [NUM_CHANNELS-1:0]   line_tip_input, line_ring_input, diff_select,
   input wire logic [NUM_CHANNELS-1:0]   line_sample, internal_programmable_resistor_en,
   input wire logic [NUM_CHANNELS-1:0]   full_internal_en,
   input wire logic [2*NUM_CHANNELS-1:0] resistor_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // helpers
   logic [1:0]              up;
   logic [NUM_CHANNELS-1:0] code_nz;
   // up guards $past against values from before the synchronisers filled
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   end
   always_comb begin
      for (int c = 0; c < NUM_CHANNELS; c++) code_nz[c] = |resistor_code[2*c+:2];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ==========
   // properties
   sequence s_pin_low; !global_hiz_force_pin [*3]; endsequence
   sequence s_quiet;
      up == 2'h3 && !($past(psel) && $past(penable) && $past(pwrite))
      && $past(global_hiz_force_pin, 2) == $past(global_hiz_force_pin, 3);
   endsequence
   property p_force_ext; s_pin_low |-> internal_programmable_resistor_en == '0; endproperty
   property p_full; (full_internal_en & ~internal_programmable_resistor_en) == '0; endproperty
   property p_single; (internal_programmable_resistor_en & ~diff_select) == '0; endproperty
   property p_code; (code_nz & ~internal_programmable_resistor_en) == '0; endproperty
   property p_hold;
      s_quiet |-> $stable(internal_programmable_resistor_en) && $stable(resistor_code);
   endproperty
   property p_sample;
      up[1] |-> line_sample == (diff_select & ($past(line_tip_input, 2)
         ^ $past(line_ring_input, 2)) | ~diff_select & $past(line_tip_input, 2));
   endproperty
   property p_ready; psel |-> pready; endproperty
   property p_err; pslverr |-> psel && penable; endproperty
   a_force_ext: assert property (p_force_ext) else $error("internal match with pin low");
   a_full: assert property (p_full) else $error("full without internal");
   a_single: assert property (p_single) else $error("internal match single ended");
   a_code: assert property (p_code) else $error("resistor code while external");
   a_hold: assert property (p_hold) else $error("mode moved without cause");
   a_sample: assert property (p_sample) else $error("line sample wrong");
   a_ready: assert property (p_ready) else $error("pready low");
   a_err: assert property (p_err) else $error("pslverr outside access");
endmodule
bind rx_termination_control rx_term_asserts rx_term_asserts_inst (.clk_sys, .reset_n,
   .psel, .penable, .pwrite, .pready, .pslverr, .global_hiz_force_pin, .line_tip_input,
   .line_ring_input, .diff_select, .line_sample, .internal_programmable_resistor_en,
   .full_internal_en, .resistor_code);
`default_nettype wire

// ---- tb/rx_line_model.sv ----
// line side model: tip and ring levels of all channels
// assumes: the design samples them through its own synchronisers
`default_nettype none
module rx_line_model
   import rx_term_pkg::*;
(
   // clock
   input  wire logic               clk_sys,
   // line levels
   output logic [NUM_CHANNELS-1:0] tip,
   output logic [NUM_CHANNELS-1:0] ring
);
   timeunit 1ns;
   timeprecision 1ps;
   initial tip = 29'h0AAAAAAA;
   initial ring = 29'h13579BDF;
   // both wires move every cycle so a stale sample cannot pass
   always @(posedge clk_sys) begin
      tip <= {tip[27:0], ~tip[28]};
      ring <= {ring[0], ring[28:1]} ^ tip;
   end
endmodule
`default_nettype wire

// ---- tb/tb_rx_termination_control.sv ----
// bench for rx_termination_control: apb config and global pin forcing
// assumes: design, checker and line model compiled before it
`default_nettype none
module tb_rx_termination_control;
   import rx_term_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pin = 1'b0, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, x = 32'd84987;
   logic [NUM_CHANNELS-1:0] tip, ring, diff_select, line_sample, ipr_en, full_en;
   logic [2*NUM_CHANNELS-1:0] resistor_code;
   logic [CFG_W-1:0] cfg [NUM_CHANNELS];
   logic [144:0] v;
   int fail_count = 0, checked = 0;
   always #4 clk_sys = ~clk_sys;
   rx_termination_control rx_termination_control_inst (.clk_sys, .reset_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .global_hiz_force_pin(pin),
      .line_tip_input(tip), .line_ring_input(ring), .diff_select, .line_sample,
      .internal_programmable_resistor_en(ipr_en), .full_internal_en(full_en), .resistor_code);
   rx_line_model rx_line_model_inst (.clk_sys, .tip, .ring);
   // ==========
   // helpers
   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [144:0] expv();
      logic i;
      logic [144:0] v;
      v = '0;
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         i = pin & !cfg[c][SINGLE_POS] & !cfg[c][TERM_EXT_POS];
         v[116+c] = !cfg[c][SINGLE_POS];
         v[87+c] = i;
         v[58+c] = i & cfg[c][PART_FULL_POS];
         if (i) v[2*c+:2] = cfg[c][1:0];
      end
      return v;
   endfunction
   task automatic chk(input logic [144:0] s, input logic [144:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %0t diff %h", $time, s ^ e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic look();
      repeat (3) @(posedge clk_sys);
      #1 chk({diff_select, ipr_en, full_en, resistor_code}, expv());
   endtask
   task automatic stop_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      #100000;
      fail_count++;
      stop_test();
   end
   initial begin
      foreach (cfg[c]) cfg[c] = CFG_RESET;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      apb(1'b0, CFG_BASE + 12'h070, ZERO_WORD);
      chk(rd, CFG_RESET);
      // pin driven high so every channel's own bits set its matching; single-ended and external configs still get external
      pin <= 1'b1;
      // channel 0 walks every code, mode and reception choice
      for (int k = 0; k < 32; k++) begin
         cfg[0] = k[7:0];
         rd = rnd();
         apb(1'b1, CFG_BASE, {rd[31:8], cfg[0]});
         look();
      end
      for (int c = 1; c < NUM_CHANNELS; c++) begin
         rd = rnd();
         // every channel is taken as transformer coupled, so full internal is legal
         cfg[c] = rd[7:0] & 8'h1F;
         apb(1'b1, CFG_BASE + 12'(4*c), {rd[31:8], cfg[c]});
      end
      look();
      for (int c = 0; c < NUM_CHANNELS; c += 7) begin
         apb(1'b0, CFG_BASE + 12'(4*c), ZERO_WORD);
         chk(rd, cfg[c]);
      end
      apb(1'b1, STATUS_BASE, 32'h000000FF);
      chk(err, 1'b1);
      apb(1'b0, 12'h300, ZERO_WORD);
      chk(err, 1'b1);
      look();
      pin <= 1'b0;
      look();
      pin <= 1'b1;
      look();
      apb(1'b0, PIN_STATUS, ZERO_WORD);
      chk(rd, 1'b1);
      v = expv();
      apb(1'b0, STATUS_BASE + 12'h01C, ZERO_WORD);
      chk(rd, {v[116+7], v[58+7], v[87+7]});
      pin <= 1'b0;
      look();
      apb(1'b0, PIN_STATUS, ZERO_WORD);
      chk(rd, 1'b0);
      v = expv();
      apb(1'b0, STATUS_BASE + 12'h01C, ZERO_WORD);
      chk(rd, {v[116+7], v[58+7], v[87+7]});
      stop_test();
   end
endmodule
`default_nettype wire
